/* hw/pasmp_top.sv */
`timescale 1ns/1ps
module pasmp_top
   import pasmp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic signed [IN_W-1:0] analog_input_pos,
   input wire logic signed [IN_W-1:0] analog_input_neg,
   input wire logic disturb,
   output pasmp_word_t sample_out,
   output logic word_suspect,
   output logic word_valid
);
   // Rising-edge group: input hold, stage 3 hold, raw bits, output buffer
   logic [UNS_W-1:0] track_hold_stage;
   logic in_range_hi;
   logic in_range_lo;
   logic [UNS_W-1:0] hold3;
   logic [S1_BITS-1:0] c1_d;
   logic [S2_BITS-1:0] c2_d;
   pasmp_raw_t raw;
   logic [1:0] otr_pipe;
   pasmp_word_t out_word;
   logic [LATENCY-1:0] fill;
   logic [LATENCY-1:0] spoil;
   logic [UNS_W-1:0] next_track_hold_stage;
   logic next_hi;
   logic next_lo;
   logic [UNS_W-1:0] next_hold3;
   logic [S1_BITS-1:0] next_c1_d;
   logic [S2_BITS-1:0] next_c2_d;
   pasmp_raw_t next_raw;
   logic [1:0] next_otr_pipe;
   pasmp_word_t next_out_word;
   logic [LATENCY-1:0] next_fill;
   logic [LATENCY-1:0] next_spoil;
   // Falling-edge group: stage 2 and stage 4 holds
   logic [UNS_W-1:0] hold2;
   logic [S1_BITS-1:0] c1_n;
   logic [UNS_W-1:0] hold4;
   logic [S1_BITS-1:0] c1_m;
   logic [S2_BITS-1:0] c2_m;
   logic [S3_BITS-1:0] c3_m;
   logic [UNS_W-1:0] next_hold2;
   logic [S1_BITS-1:0] next_c1_n;
   logic [UNS_W-1:0] next_hold4;
   logic [S1_BITS-1:0] next_c1_m;
   logic [S2_BITS-1:0] next_c2_m;
   logic [S3_BITS-1:0] next_c3_m;

   logic signed [DIFF_W-1:0] diff;
   logic [S1_BITS-1:0] c1;
   logic [S2_BITS-1:0] c2;
   logic [S3_BITS-1:0] c3;
   logic [S4_BITS-1:0] c4;
   logic [UNS_W-1:0] res1;
   logic [UNS_W-1:0] res2;
   logic [UNS_W-1:0] res3;
   logic [UNS_W-1:0] corrected;

   // Adds the weighted stage codes back into one offset word
   function automatic logic [UNS_W-1:0] correct(input pasmp_raw_t r);
      logic [UNS_W-1:0] sum;
      sum = (UNS_W'(r.c1) << S1_SHIFT) + (UNS_W'(r.c2) << S2_SHIFT) + (UNS_W'(r.c3) << S3_SHIFT);
      sum = sum + UNS_W'(r.c4) - CORR_OFFSET;
      return sum;
   endfunction

   pasmp_flash_stage #(.CODE_W(S1_BITS), .SHIFT(S1_SHIFT), .OFFSET(S1_OFFSET)) u_stage1 (
      .held(track_hold_stage),
      .code(c1),
      .residue(res1)
   );
   pasmp_flash_stage #(.CODE_W(S2_BITS), .SHIFT(S2_SHIFT), .OFFSET(S2_OFFSET)) u_stage2 (
      .held(hold2),
      .code(c2),
      .residue(res2)
   );
   pasmp_flash_stage #(.CODE_W(S3_BITS), .SHIFT(S3_SHIFT), .OFFSET(S3_OFFSET)) u_stage3 (
      .held(hold3),
      .code(c3),
      .residue(res3)
   );
   pasmp_flash_stage #(.CODE_W(S4_BITS), .SHIFT(S4_SHIFT), .OFFSET(S4_OFFSET)) u_stage4 (
      .held(hold4),
      .code(c4),
      .residue()
   );

   assign corrected = correct(raw);

   // Input track-and-hold: clamp at full scale, then offset form for the flashes
   always_comb begin
      diff = DIFF_W'(analog_input_pos) - DIFF_W'(analog_input_neg);
      next_hi = diff > POS_FS;
      next_lo = diff < NEG_FS;
      if (next_hi) begin
         next_track_hold_stage = UNS_W'(CODE_POS_FS) + MID_OFFSET;
      end else if (next_lo) begin
         next_track_hold_stage = UNS_W'(CODE_NEG_FS) - MID_OFFSET;
      end else begin
         next_track_hold_stage = UNS_W'(diff) + MID_OFFSET;
      end
   end

   // Input held from the rising edge through the high phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         track_hold_stage <= MID_OFFSET;
         in_range_hi <= 1'b0;
         in_range_lo <= 1'b0;
      end else begin
         track_hold_stage <= next_track_hold_stage;
         in_range_hi <= next_hi;
         in_range_lo <= next_lo;
      end
   end

   // Second stage holds the first residue on the falling edge
   always_comb begin
      next_hold2 = res1;
      next_c1_n = c1;
   end

   always_ff @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold2 <= '0;
         // Mid-scale code, so the reset-held input reads as zero
         c1_n <= S1_BITS'(MID_OFFSET >> S1_SHIFT);
      end else begin
         hold2 <= next_hold2;
         c1_n <= next_c1_n;
      end
   end

   // Third stage holds on the rising edge; earlier codes wait alongside
   always_comb begin
      next_hold3 = res2;
      next_c1_d = c1_n;
      next_c2_d = c2;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold3 <= '0;
         c1_d <= '0;
         c2_d <= '0;
      end else begin
         hold3 <= next_hold3;
         c1_d <= next_c1_d;
         c2_d <= next_c2_d;
      end
   end

   // Fourth stage holds on the falling edge with the earlier codes
   always_comb begin
      next_hold4 = res3;
      next_c1_m = c1_d;
      next_c2_m = c2_d;
      next_c3_m = c3;
   end

   always_ff @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold4 <= '0;
         c1_m <= '0;
         c2_m <= '0;
         c3_m <= '0;
      end else begin
         hold4 <= next_hold4;
         c1_m <= next_c1_m;
         c2_m <= next_c2_m;
         c3_m <= next_c3_m;
      end
   end

   // Raw bits, out-of-range delay and the output buffer
   always_comb begin
      next_raw = '{c1: c1_m, c2: c2_m, c3: c3_m, c4: c4};
      next_otr_pipe = {otr_pipe[0], in_range_hi | in_range_lo};
      next_out_word.data = corrected[WORD_W-1:0] ^ CODE_NEG_FS;
      next_out_word.out_of_range_flag = otr_pipe[1];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         raw <= '0;
         otr_pipe <= '0;
         out_word <= '{data: CODE_ZERO, out_of_range_flag: 1'b0};
      end else begin
         raw <= next_raw;
         otr_pipe <= next_otr_pipe;
         out_word <= next_out_word;
      end
   end

   // Pipeline fill since reset and words a disturbance may have spoiled
   always_comb begin
      next_fill = {fill[LATENCY-2:0], 1'b1};
      next_spoil = {spoil[LATENCY-2:0], 1'b0} | {LATENCY{disturb}};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fill <= '0;
         spoil <= '0;
      end else begin
         fill <= next_fill;
         spoil <= next_spoil;
      end
   end

   assign sample_out = out_word;
   assign word_suspect = spoil[LATENCY-1];
   assign word_valid = fill[LATENCY-1] & ~spoil[LATENCY-1];
endmodule

/* hw/pasmp_pkg.sv */
package pasmp_pkg;
   localparam int IN_W = 14;
   localparam int DIFF_W = 15;
   localparam int WORD_W = 12;
   localparam int UNS_W = 13;
   localparam int RAW_W = 15;
   localparam int LATENCY = 3;
   localparam int S1_BITS = 4;
   localparam int S2_BITS = 4;
   localparam int S3_BITS = 3;
   localparam int S4_BITS = 4;
   localparam int S1_SHIFT = 8;
   localparam int S2_SHIFT = 5;
   localparam int S3_SHIFT = 3;
   localparam int S1_OFFSET = 0;
   localparam int S2_OFFSET = 16;
   localparam int S3_OFFSET = 0;
   localparam int S4_SHIFT = 0;
   localparam int S4_OFFSET = 0;
   localparam logic [UNS_W-1:0] CORR_OFFSET = 13'h0010;
   localparam logic signed [DIFF_W-1:0] POS_FS = 15'sh07ff;
   localparam logic signed [DIFF_W-1:0] NEG_FS = -15'sh0800;
   localparam logic [WORD_W-1:0] CODE_POS_FS = 12'h7ff;
   localparam logic [WORD_W-1:0] CODE_NEG_FS = 12'h800;
   localparam logic [WORD_W-1:0] CODE_ZERO = 12'h000;
   localparam logic [UNS_W-1:0] MID_OFFSET = 13'h0800;
   localparam real MIN_CLK_KHZ = 10.0;

   typedef struct packed {
      logic [WORD_W-1:0] data;
      logic out_of_range_flag;
   } pasmp_word_t;

   typedef struct packed {
      logic [S1_BITS-1:0] c1;
      logic [S2_BITS-1:0] c2;
      logic [S3_BITS-1:0] c3;
      logic [S4_BITS-1:0] c4;
   } pasmp_raw_t;
endpackage

/* hw/pasmp_flash_stage.sv */
`timescale 1ns/1ps
module pasmp_flash_stage
   import pasmp_pkg::*;
#(
   parameter int CODE_W = 4,
   parameter int SHIFT = 8,
   parameter int OFFSET = 0
) (
   input wire logic [UNS_W-1:0] held,
   output logic [CODE_W-1:0] code,
   output logic [UNS_W-1:0] residue
);
   logic [UNS_W-1:0] biased;
   logic [UNS_W-1:0] coarse;

   // Coarse guess, then subtract its weight to leave the residue
   always_comb begin
      biased = held + UNS_W'(OFFSET);
      coarse = biased >> SHIFT;
      code = coarse[CODE_W-1:0];
      residue = biased - (coarse << SHIFT);
   end
endmodule

/* test/pasmp_checker.sv */
`timescale 1ns/1ps
module pasmp_checker
   import pasmp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic signed [IN_W-1:0] analog_input_pos,
   input wire logic signed [IN_W-1:0] analog_input_neg,
   input wire logic disturb,
   input wire pasmp_word_t sample_out,
   input wire logic word_suspect,
   input wire logic word_valid
);
   logic signed [DIFF_W-1:0] diff;
   logic [WORD_W-1:0] lo;
   logic [1:0] fill;
   logic [1:0] next_fill;
   assign diff = DIFF_W'(analog_input_pos) - DIFF_W'(analog_input_neg);
   assign lo = diff[WORD_W-1:0];
   always_comb next_fill = (fill == 2'h3) ? fill : fill + 2'h1;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) fill <= 2'h0;
      else fill <= next_fill;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_suspect_run;
      word_suspect [*3];
   endsequence
   a_inrange_word: assert property (diff <= POS_FS && diff >= NEG_FS |->
      ##4 sample_out.data == $past(lo, 4) && !sample_out.out_of_range_flag) else $error("bad word");
   a_high_sat: assert property (diff > POS_FS |-> ##4 sample_out == {CODE_POS_FS, 1'b1})
      else $error("bad high");
   a_low_sat: assert property (diff < NEG_FS |-> ##4 sample_out == {CODE_NEG_FS, 1'b1})
      else $error("bad low");
   a_flag_code: assert property (sample_out.out_of_range_flag |->
      sample_out.data == CODE_POS_FS || sample_out.data == CODE_NEG_FS) else $error("bad pair");
   a_suspect_run: assert property (disturb |-> ##1 s_suspect_run) else $error("short run");
   a_suspect_cause: assert property ($rose(word_suspect) |-> $past(disturb)) else $error("no cause");
   a_suspect_end: assert property (word_suspect |->
      $past(disturb, 1) || $past(disturb, 2) || $past(disturb, 3)) else $error("long run");
   a_valid_fill: assert property (word_valid == (fill == 2'h3 && !word_suspect))
      else $error("bad valid");
endmodule
bind pasmp_top pasmp_checker pasmp_checker_inst (.clk(clk), .rst_n(rst_n),
   .analog_input_pos(analog_input_pos), .analog_input_neg(analog_input_neg), .disturb(disturb),
   .sample_out(sample_out), .word_suspect(word_suspect), .word_valid(word_valid));

/* test/pasmp_capture.sv */
`timescale 1ns/1ps
module pasmp_capture
   import pasmp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic word_valid,
   output int dropped
);
   // Counts words thrown away after start or a disturbance
   initial dropped = 0;
   always @(posedge clk) begin
      if (rst_n && !word_valid) dropped <= dropped + 1;
   end
endmodule

/* test/pasmp_top_tb.sv */
`timescale 1ns/1ps
module pasmp_top_tb;
   import pasmp_pkg::*;
   logic clk, rst_n, disturb, word_suspect, word_valid;
   logic signed [IN_W-1:0] pos, neg;
   pasmp_word_t sample_out;
   pasmp_word_t q[$];
   int error_cnt, compares, cyc, dropped;
   pasmp_top pasmp_top_inst (.clk(clk), .rst_n(rst_n), .analog_input_pos(pos), .analog_input_neg(neg),
      .disturb(disturb), .sample_out(sample_out), .word_suspect(word_suspect), .word_valid(word_valid));
   pasmp_capture pasmp_capture_inst (.clk(clk), .rst_n(rst_n), .word_valid(word_valid), .dropped(dropped));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [12:0] got, input logic [12:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic step(input int p, input int n, input logic d);
      logic signed [DIFF_W-1:0] df;
      @(negedge clk);
      if (q.size() > 3) chk(sample_out, q.pop_front());
      pos = p[IN_W-1:0];
      neg = n[IN_W-1:0];
      disturb = d;
      df = DIFF_W'(p - n);
      if (df > POS_FS) q.push_back({CODE_POS_FS, 1'b1});
      else if (df < NEG_FS) q.push_back({CODE_NEG_FS, 1'b1});
      else q.push_back({df[WORD_W-1:0], 1'b0});
   endtask
   task automatic t_stream();
      int v[7] = '{0, 2047, -2048, -1, 1000, -5, 4};
      foreach (v[i]) step(v[i], 0, 1'b0);
      step(100, 600, 1'b0);
      repeat (4) step(0, 0, 1'b0);
   endtask
   task automatic t_range();
      int v[6] = '{2047, 2048, -2048, -2049, 8191, -8192};
      foreach (v[i]) step(v[i], (i > 3) ? -v[i] - 1 : 0, 1'b0);
      repeat (4) step(0, 0, 1'b0);
   endtask
   task automatic t_disturb();
      step(300, 0, 1'b1);
      for (int i = 0; i < 5; i++) begin
         step(i, 0, 1'b0);
         chk({11'h0, word_suspect, word_valid}, (i < 3) ? 13'h2 : 13'h1);
      end
   endtask
   task automatic t_reset();
      @(negedge clk);
      rst_n = 1'b0;
      #1;
      chk({sample_out.data, word_valid}, 13'h0);
      @(negedge clk);
      rst_n <= 1'b1;
      q.delete();
      for (int i = 1; i < 9; i++) begin
         step(i, 0, 1'b0);
         chk({12'h0, word_valid}, {12'h0, i > 2});
         if (i == 3) chk(sample_out, {CODE_ZERO, 1'b0});
      end
   endtask
   task automatic results();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         error_cnt++;
         results();
      end
   end
   initial begin
      rst_n = 1'b0;
      disturb = 1'b0;
      pos = 14'h0;
      neg = 14'h0;
      repeat (6) @(negedge clk);
      rst_n <= 1'b1;
      t_stream();
      t_range();
      t_disturb();
      t_reset();
      chk(13'(dropped), 13'h9);
      results();
   end
endmodule
